// >>> src/iefl_irq_ctrl.sv
// Purpose: Interrupt enable and flag logic feeding one core request.
// Assumes: Peripheral events arrive on clk; pin inputs are asynchronous.
// Notes: Vectoring, stacking and sleep handling live in the core.
`timescale 1ns/1ps

// How it works
// [RQ1] Peripheral requests also need the group enable.
// [RQ2] Flags set regardless of any enable.
// [RQ3] Software clears a flag before enabling it.
// [RQ4] Timer0 overflow enable sits in bit 5.
// [RQ5] Timer0 rollover sets bit 2, sticky.
// [RQ6] External pin enable sits in bit 4.
// [RQ7] External pin edge sets bit 1, sticky.
// [RQ8] Masked pin change sets bit 0.
// [RQ9] First peripheral enable bits gate their flags.
// [RQ10] Second peripheral enable bits gate their flags.
// [RQ11] ADC completion sets first flag bit 6.
// [RQ12] Bus collision shows in first flag bit 5.
// [RQ13] Serial port event shows in bit 4.
// [RQ14] Timer2 match sets bit 1, sticky.
// [RQ15] Timer1 rollover sets bit 0, sticky.
// [RQ16] Unimplemented bits read zero, ignore writes.
// [RQ17] Global enable passes or blocks all; reset clears.
// [RQ18] Service clears global enable; return sets it.
// [RQ19] Edge select picks rising or falling edge.
// [RQ20] Second flag register holds power fault flags.
// [RQ21] Request needs global enable and enabled flag.
// [RQ22] Reset clears every enable and flag.
module iefl_irq_ctrl (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [2:0] addr, // Register address.
  input wire logic [7:0] wr_data, // Register write data.
  input wire logic wr_stb, // One-cycle write strobe.
  input wire logic rd_stb, // One-cycle read strobe.
  output logic [7:0] rd_data, // Read data, valid the cycle after rd_stb.
  input wire logic timer0_rollover, // Timer0 count rolled over.
  input wire logic ext_pin, // External request pin, asynchronous.
  input wire logic [7:0] change_pins, // Monitored pins, asynchronous.
  input wire logic adc_done, // ADC conversion completed.
  input wire logic bus_collision, // Serial port bus collision.
  input wire logic serial_event, // Serial port event.
  input wire logic timer2_match, // Timer2 matched its period.
  input wire logic timer1_rollover, // Timer1 rolled over.
  input wire logic output_undervolt, // Output undervoltage fault.
  input wire logic overcurrent, // Output overcurrent fault.
  input wire logic output_overvolt, // Output overvoltage fault.
  input wire logic input_uvlo, // Input voltage below its limit.
  input wire logic service_taken, // Core enters the service routine.
  input wire logic return_from_service, // Core leaves the service routine.
  output logic irq_req // Request to the core, active high.
);

  // Enable registers and configuration.
  logic global_irq_enable_r;
  logic global_irq_enable_nxt;
  logic [7:0] core_en_r;
  logic [7:0] core_en_nxt;
  logic [7:0] en_one_r;
  logic [7:0] en_one_nxt;
  logic [7:0] en_two_r;
  logic [7:0] en_two_nxt;
  logic [7:0] edge_cfg_r;
  logic [7:0] edge_cfg_nxt;
  logic [7:0] pin_mask_r;
  logic [7:0] pin_mask_nxt;

  // Output registers.
  logic irq_req_r;
  logic irq_req_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  // Address hits, shared by the write strobes and the read selection.
  wire hit_core;
  wire hit_en_one;
  wire hit_en_two;
  wire hit_flag_one;
  wire hit_flag_two;
  wire hit_edge;
  wire hit_mask;

  // Write decode strobes.
  wire wr_core;
  wire wr_en_one;
  wire wr_en_two;
  wire wr_flag_one;
  wire wr_flag_two;
  wire wr_edge;
  wire wr_mask;

  // Pin edge detection results.
  wire [8:0] pin_rise;
  wire [8:0] pin_fall;
  wire ext_evt;
  wire pin_change_detect;
  wire edge_rising;

  // Flag set vectors and flag state.
  wire [7:0] core_set;
  wire [7:0] flag_one_set;
  wire [7:0] flag_two_set;
  wire [7:0] core_flags;
  wire [7:0] flag_one;
  wire [7:0] flag_two;

  // Named enable bits.
  wire periph_group_enable;
  wire timer0_overflow_enable;
  wire ext_pin_irq_enable;
  wire pin_change_enable;

  // Pending request terms.
  wire core_pending;
  wire periph_one_pending;
  wire periph_two_pending;
  wire periph_pending;

  // Read selection.
  wire [7:0] core_view;
  logic [7:0] rd_mux;

  // One hit per register offset; the unmapped offset hits nothing.
  assign hit_core = (addr == iefl_pkg::ADDR_CORE_CTRL);
  assign hit_en_one = (addr == iefl_pkg::ADDR_EN_ONE);
  assign hit_en_two = (addr == iefl_pkg::ADDR_EN_TWO);
  assign hit_flag_one = (addr == iefl_pkg::ADDR_FLAG_ONE);
  assign hit_flag_two = (addr == iefl_pkg::ADDR_FLAG_TWO);
  assign hit_edge = (addr == iefl_pkg::ADDR_EDGE_CFG);
  assign hit_mask = (addr == iefl_pkg::ADDR_PIN_MASK);

  // Address decode for writes; each register has one strobe.
  assign wr_core = wr_stb && hit_core;
  assign wr_en_one = wr_stb && hit_en_one;
  assign wr_en_two = wr_stb && hit_en_two;
  assign wr_flag_one = wr_stb && hit_flag_one;
  assign wr_flag_two = wr_stb && hit_flag_two;
  assign wr_edge = wr_stb && hit_edge;
  assign wr_mask = wr_stb && hit_mask;

  // Named views of the enable bits.
  assign periph_group_enable = core_en_r[iefl_pkg::CORE_GROUP_EN_BIT];
  assign timer0_overflow_enable = core_en_r[iefl_pkg::CORE_TIMER0_EN_BIT]; // [RQ4]
  assign ext_pin_irq_enable = core_en_r[iefl_pkg::CORE_EXTIE_BIT]; // [RQ6]
  assign pin_change_enable = core_en_r[iefl_pkg::CORE_CHANGE_EN_BIT];
  assign edge_rising = edge_cfg_r[iefl_pkg::EDGE_SEL_BIT];

  // The external pin and the monitored pins share one synchroniser.
  // Pulses narrower than one clock may be missed; that is the price of
  // filtering metastability out of the flag logic.
  iefl_edge_sync #(
    .W(iefl_pkg::PIN_COUNT + 1)
  ) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .pin({ext_pin, change_pins}),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // External event follows the selected edge polarity.
  assign ext_evt = edge_rising ? pin_rise[8] : pin_fall[8]; // [RQ19]

  // Any masked pin toggling in either direction counts as a change.
  assign pin_change_detect = |((pin_rise[7:0] | pin_fall[7:0]) & pin_mask_r); // [RQ8]

  // Set vectors; sources set their flags whatever the enables are.
  assign core_set = {5'h00, timer0_rollover, ext_evt, pin_change_detect}; // [RQ2] [RQ5] [RQ7]
  assign flag_one_set = {1'b0, adc_done, bus_collision, serial_event, 2'h0,
                         timer2_match, timer1_rollover}; // [RQ11] [RQ12] [RQ13] [RQ14] [RQ15]
  assign flag_two_set = {output_undervolt, 1'b0, overcurrent, output_overvolt, 2'h0,
                         input_uvlo, 1'b0}; // [RQ20]

  // One sticky cell per implemented flag bit; other positions stay zero.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flags
      if (iefl_pkg::CORE_FLAG_MASK[gi]) begin : g_core
        iefl_flag_cell u_cell (
          .clk(clk),
          .nrst(nrst),
          .set_evt(core_set[gi]),
          .wr_en(wr_core),
          .wr_val(wr_data[gi]),
          .flag(core_flags[gi])
        );
      end else begin : g_core_none
        assign core_flags[gi] = 1'b0; // [RQ16]
      end
      if (iefl_pkg::PERIPH_ONE_MASK[gi]) begin : g_one
        iefl_flag_cell u_cell (
          .clk(clk),
          .nrst(nrst),
          .set_evt(flag_one_set[gi]),
          .wr_en(wr_flag_one),
          .wr_val(wr_data[gi]),
          .flag(flag_one[gi])
        );
      end else begin : g_one_none
        assign flag_one[gi] = 1'b0; // [RQ16]
      end
      if (iefl_pkg::PERIPH_TWO_MASK[gi]) begin : g_two
        iefl_flag_cell u_cell (
          .clk(clk),
          .nrst(nrst),
          .set_evt(flag_two_set[gi]),
          .wr_en(wr_flag_two),
          .wr_val(wr_data[gi]),
          .flag(flag_two[gi])
        );
      end else begin : g_two_none
        assign flag_two[gi] = 1'b0; // [RQ16]
      end
    end
  endgenerate

  // Global enable: service clears it, return sets it, software writes it.
  // Service wins so a request can never retrigger during entry.
  assign global_irq_enable_nxt = service_taken ? 1'b0 : // [RQ18]
                                 return_from_service ? 1'b1 :
                                 wr_core ? wr_data[iefl_pkg::CORE_GLOBAL_EN_BIT] :
                                 global_irq_enable_r;

  // Enable and configuration writes keep only implemented bits.
  assign core_en_nxt = wr_core ? (wr_data & iefl_pkg::CORE_EN_MASK) : core_en_r;
  assign en_one_nxt = wr_en_one ? (wr_data & iefl_pkg::PERIPH_ONE_MASK) : en_one_r; // [RQ9] [RQ16]
  assign en_two_nxt = wr_en_two ? (wr_data & iefl_pkg::PERIPH_TWO_MASK) : en_two_r; // [RQ10] [RQ16]
  assign edge_cfg_nxt = wr_edge ? (wr_data & iefl_pkg::EDGE_CFG_MASK) : edge_cfg_r;
  assign pin_mask_nxt = wr_mask ? wr_data : pin_mask_r;

  // Core group: each flag pairs with its own enable.
  assign core_pending = (core_flags[iefl_pkg::CORE_TIMER0_FLAG_BIT] & timer0_overflow_enable) |
                        (core_flags[iefl_pkg::CORE_EXTIF_BIT] & ext_pin_irq_enable) |
                        (core_flags[iefl_pkg::CORE_CHANGE_FLAG_BIT] & pin_change_enable);

  // Peripheral group: flags pair bit for bit with their enables.
  assign periph_one_pending = |(flag_one & en_one_r);
  assign periph_two_pending = |(flag_two & en_two_r);
  assign periph_pending = periph_group_enable &
                          (periph_one_pending | periph_two_pending); // [RQ1]

  // The request looks at the next global enable, so a write that clears
  // it drops any request due in the following cycle; the flag stays set.
  assign irq_req_nxt = global_irq_enable_nxt & (core_pending | periph_pending); // [RQ17] [RQ21]

  // Read view of the core control register.
  assign core_view = {global_irq_enable_r, core_en_r[6:3], core_flags[2:0]};

  // Read selection; unmapped offsets read as zero.
  always_comb begin
    rd_mux = iefl_pkg::READ_IDLE; // [RQ16]
    if (hit_core) begin
      rd_mux = core_view;
    end else if (hit_en_one) begin
      rd_mux = en_one_r;
    end else if (hit_en_two) begin
      rd_mux = en_two_r;
    end else if (hit_flag_one) begin
      rd_mux = flag_one;
    end else if (hit_flag_two) begin
      rd_mux = flag_two;
    end else if (hit_edge) begin
      rd_mux = edge_cfg_r;
    end else if (hit_mask) begin
      rd_mux = pin_mask_r;
    end
  end

  // Read data stands for exactly one cycle after the strobe.
  assign rd_data_nxt = rd_stb ? rd_mux : iefl_pkg::READ_IDLE;

  // Global enable; any reset clears it so nothing fires before software is ready.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      global_irq_enable_r <= iefl_pkg::GLOBAL_EN_RESET; // [RQ17] [RQ22]
    end else begin
      global_irq_enable_r <= global_irq_enable_nxt;
    end
  end

  // Core group enables.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_en_r <= iefl_pkg::CORE_EN_RESET; // [RQ22]
    end else begin
      core_en_r <= core_en_nxt;
    end
  end

  // First peripheral enables.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_one_r <= iefl_pkg::EN_RESET; // [RQ22]
    end else begin
      en_one_r <= en_one_nxt;
    end
  end

  // Second peripheral enables.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_two_r <= iefl_pkg::EN_RESET; // [RQ22]
    end else begin
      en_two_r <= en_two_nxt;
    end
  end

  // Edge select; it leaves reset on the rising edge.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      edge_cfg_r <= iefl_pkg::EDGE_CFG_RESET;
    end else begin
      edge_cfg_r <= edge_cfg_nxt;
    end
  end

  // Pin change mask; every pin is ignored until software picks it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_mask_r <= iefl_pkg::PIN_MASK_RESET;
    end else begin
      pin_mask_r <= pin_mask_nxt;
    end
  end

  // Request register, so the core sees a clean level straight from a flop.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_req_r <= 1'b0;
    end else begin
      irq_req_r <= irq_req_nxt;
    end
  end

  // Read data register; it idles at zero between reads.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data_r <= iefl_pkg::READ_IDLE;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign irq_req = irq_req_r;
  assign rd_data = rd_data_r;

endmodule // iefl_irq_ctrl

// >>> src/iefl_pkg.sv
// Purpose: Shared constants for the interrupt enable and flag logic.
// Assumes: Eight-bit registers reached over a plain strobe port.
// Notes: Every offset, bit position, mask and reset value lives here, except the zero reset of the request register.
package iefl_pkg;

  // Widths of the register port.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PIN_COUNT = 8;

  // Register offsets.
  localparam logic [2:0] ADDR_CORE_CTRL = 3'h0;
  localparam logic [2:0] ADDR_EN_ONE = 3'h1;
  localparam logic [2:0] ADDR_EN_TWO = 3'h2;
  localparam logic [2:0] ADDR_FLAG_ONE = 3'h3;
  localparam logic [2:0] ADDR_FLAG_TWO = 3'h4;
  localparam logic [2:0] ADDR_EDGE_CFG = 3'h5;
  localparam logic [2:0] ADDR_PIN_MASK = 3'h6;

  // Field positions in the core control register.
  localparam int CORE_GLOBAL_EN_BIT = 7;
  localparam int CORE_GROUP_EN_BIT = 6;
  localparam int CORE_TIMER0_EN_BIT = 5;
  localparam int CORE_EXTIE_BIT = 4;
  localparam int CORE_CHANGE_EN_BIT = 3;
  localparam int CORE_TIMER0_FLAG_BIT = 2;
  localparam int CORE_EXTIF_BIT = 1;
  localparam int CORE_CHANGE_FLAG_BIT = 0;

  // Field positions in the first peripheral enable and flag registers.
  localparam int P1_ADC_BIT = 6;
  localparam int P1_BCL_BIT = 5;
  localparam int P1_SSP_BIT = 4;
  localparam int P1_T2_BIT = 1;
  localparam int P1_T1_BIT = 0;

  // Field positions in the second peripheral enable and flag registers.
  localparam int P2_UV_BIT = 7;
  localparam int P2_OC_BIT = 5;
  localparam int P2_OV_BIT = 4;
  localparam int P2_VIN_BIT = 1;

  // Field position of the external edge select.
  localparam int EDGE_SEL_BIT = 6;

  // Implemented bit masks; all other positions read as zero.
  localparam logic [7:0] CORE_EN_MASK = 8'h78;
  localparam logic [7:0] CORE_FLAG_MASK = 8'h07;
  localparam logic [7:0] PERIPH_ONE_MASK = 8'h73;
  localparam logic [7:0] PERIPH_TWO_MASK = 8'hB2;
  localparam logic [7:0] EDGE_CFG_MASK = 8'h40;

  // Reset values.
  localparam logic [7:0] CORE_EN_RESET = 8'h00;
  localparam logic GLOBAL_EN_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] EDGE_CFG_RESET = 8'h40;
  localparam logic [7:0] PIN_MASK_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// >>> src/iefl_edge_sync.sv
// Purpose: Two-flop synchroniser with edge detection for pin inputs.
// Assumes: Pins are asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module iefl_edge_sync #(
  parameter int W = 9
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [W-1:0] pin, // Raw pin levels.
  output logic [W-1:0] rise, // One-cycle pulse on a rising edge.
  output logic [W-1:0] fall // One-cycle pulse on a falling edge.
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  // The stages follow the pins even in reset, so a pin that idles high
  // reports no false edge once reset is released.
  always_ff @(posedge clk) begin
    meta_r <= pin;
    sync_r <= meta_r;
    last_r <= sync_r;
  end

  // Edges compare the second stage with its delayed copy; none in reset.
  assign rise = nrst ? (sync_r & ~last_r) : '0;
  assign fall = nrst ? (~sync_r & last_r) : '0;

endmodule // iefl_edge_sync

// >>> src/iefl_flag_cell.sv
// Purpose: One sticky request flag with software read and write.
// Assumes: The set input is a level or pulse on clk.
// Notes: A set in the same cycle as a software clear wins.
`timescale 1ns/1ps
module iefl_flag_cell (
  input wire logic clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic set_evt, // Source condition, active high.
  input wire logic wr_en, // Software write to this bit.
  input wire logic wr_val, // Value written by software.
  output logic flag // Current flag state.
);

  // The event is tested first so it is never lost to a clear.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag <= iefl_pkg::FLAG_RESET;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (wr_en) begin
      flag <= wr_val;
    end
  end

endmodule // iefl_flag_cell

// >>> tb/iefl_irq_ctrl_monitor.sv
// Purpose: Concurrent checks on the ports of the interrupt enable and flag logic.
// Assumes: One clock; reset is synchronous and active low.
// Notes: Enables are not copied here, so checks tie reads and drops to their causes.
`timescale 1ns/1ps
module iefl_irq_ctrl_checker (
  input wire logic clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [2:0] addr, // Register address.
  input wire logic [7:0] wr_data, // Write data.
  input wire logic wr_stb, // Write strobe.
  input wire logic rd_stb, // Read strobe.
  input wire logic [7:0] rd_data, // Read data.
  input wire logic adc_done, // ADC completion event.
  input wire logic service_taken, // Core enters service.
  input wire logic return_from_service, // Core leaves service.
  input wire logic irq_req // Request to the core.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Read data shows only in its slot, so stale data cannot leak to software.
  chk_read_idle_zero: assert property (!rd_stb |=> rd_data == 8'h00)
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (rd_stb && addr == 3'h7 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_flag_one_gaps: assert property (rd_stb && addr == 3'h3 |=> (rd_data & 8'h8C) == 8'h00)
    else $error("unused flag bits set");
  chk_enable_two_gaps: assert property (rd_stb && addr == 3'h2 |=> (rd_data & 8'h4D) == 8'h00)
    else $error("unused enable bits set");
  chk_adc_flag_read: assert property (adc_done ##1 (rd_stb && addr == 3'h3) |=> rd_data[6])
    else $error("adc flag missing");
  chk_service_drop: assert property (service_taken |=> !irq_req)
    else $error("request kept after service");
  chk_service_hold: assert property (service_taken ##1 (!return_from_service && !wr_stb)[*3] |-> !irq_req)
    else $error("request during service");
  chk_gie_write_drop: assert property (wr_stb && addr == 3'h0 && !wr_data[7] && !return_from_service |=> !irq_req)
    else $error("request without global enable");
  chk_reset_quiet: assert property ($rose(nrst) |-> !irq_req && rd_data == 8'h00)
    else $error("outputs busy after reset");
  // Main scenarios seen at least once.
  cover property (service_taken);
  cover property (rd_stb && addr == 3'h7);
  cover property (adc_done ##1 (rd_stb && addr == 3'h3));
endmodule // iefl_irq_ctrl_checker

bind iefl_irq_ctrl iefl_irq_ctrl_checker u_checker (
  .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .adc_done(adc_done), .service_taken(service_taken),
  .return_from_service(return_from_service), .irq_req(irq_req)
);

// >>> tb/iefl_core_model.sv
// Purpose: Behavioural core that takes a request and returns later.
// Assumes: Armed by the bench; one service at a time.
// Notes: RET_DELAY sets how long the service routine lasts.
`timescale 1ns/1ps
module iefl_core_model #(
  parameter int RET_DELAY = 8
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic irq_req, // Request from the block.
  input wire logic serve_en, // Bench lets the core take requests.
  output logic service_taken = 1'b0, // One-cycle entry pulse.
  output logic return_from_service = 1'b0 // One-cycle exit pulse.
);
  int busy_cnt = 0;
  logic take;
  // A request is only taken while idle, so a routine is never entered twice.
  assign take = nrst && busy_cnt == 0 && irq_req && serve_en;
  // Enter on a request, then leave after a fixed routine length.
  always @(posedge clk) begin
    service_taken <= take;
    return_from_service <= nrst && busy_cnt == 1;
    busy_cnt <= !nrst ? 0 : take ? RET_DELAY : (busy_cnt != 0 ? busy_cnt - 1 : 0);
  end
endmodule // iefl_core_model

// >>> tb/iefl_irq_ctrl_tb_top.sv
// Purpose: Self-checking bench for the interrupt enable and flag logic.
// Assumes: The core model answers requests only when armed.
// Notes: Sources are packed in one vector so a table can drive them.
`timescale 1ns/1ps
module iefl_irq_ctrl_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [9:0] src = 10'h000;
  logic ext_pin = 1'b0;
  logic [7:0] change_pins = 8'h00;
  logic serve_en = 1'b0;
  logic [7:0] rd_data;
  logic service_taken, return_from_service, irq_req;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int k;
  logic [7:0] v;
  int bit_pos [10] = '{2, 6, 5, 4, 1, 0, 7, 5, 4, 1};

  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end

  iefl_irq_ctrl u_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .timer0_rollover(src[0]), .ext_pin(ext_pin),
    .change_pins(change_pins), .adc_done(src[1]), .bus_collision(src[2]),
    .serial_event(src[3]), .timer2_match(src[4]), .timer1_rollover(src[5]),
    .output_undervolt(src[6]), .overcurrent(src[7]), .output_overvolt(src[8]),
    .input_uvlo(src[9]), .service_taken(service_taken),
    .return_from_service(return_from_service), .irq_req(irq_req)
  );

  iefl_core_model u_core (
    .clk(clk), .nrst(nrst), .irq_req(irq_req), .serve_en(serve_en),
    .service_taken(service_taken), .return_from_service(return_from_service)
  );

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Each access leaves one idle cycle, so no strobe is driven twice in a step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask

  task automatic pulse(input int n);
    src[n] <= 1'b1;
    @(posedge clk);
    src[n] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ck_irq(input logic e);
    @(negedge clk);
    chk("irq_req", {7'h00, irq_req}, {7'h00, e});
    @(posedge clk);
  endtask

  task automatic clear_all();
    for (int a = 0; a < 5; a++) wr(a[2:0], 8'h00);
  endtask

  // A hang counts as a mismatch and still reaches the report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 8; k++) begin
      rd(k[2:0], v);
      chk("reset value", v, (k == 5) ? 8'h40 : 8'h00);
    end
    for (k = 1; k < 5; k++) begin
      wr(k[2:0], 8'hFF);
      rd(k[2:0], v);
      chk("implemented bits", v, k[0] ? 8'h73 : 8'hB2);
      wr(k[2:0], 8'h00);
    end
    // All sources at once with every enable off still leave their flags.
    src <= 10'h3FF;
    @(posedge clk);
    src <= 10'h000;
    rd(3'h3, v);
    chk("flag one", v, 8'h73);
    rd(3'h0, v);
    chk("timer0 flag", v, 8'h04);
    rd(3'h4, v);
    chk("flag two", v, 8'hB2);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'hFF);
    wr(3'h0, 8'h78);
    ck_irq(1'b0);
    clear_all();
    // Each source: blocked by its enable, passed by it, then blocked by the group enable, which timer0 ignores.
    for (k = 0; k < 10; k++) begin
      wr(3'h0, 8'hC0);
      pulse(k);
      ck_irq(1'b0);
      if (k == 0) wr(3'h0, 8'hE4);
      else wr(k < 6 ? 3'h1 : 3'h2, 8'h01 << bit_pos[k]);
      ck_irq(1'b1);
      wr(3'h0, k == 0 ? 8'hA4 : 8'h80);
      ck_irq(k == 0);
      clear_all();
    end
    // External pin, rising by default, then falling with its enable on.
    ext_pin <= 1'b1;
    repeat (5) @(posedge clk);
    rd(3'h0, v);
    chk("rising edge flag", v, 8'h02);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h90);
    ext_pin <= 1'b0;
    repeat (5) @(posedge clk);
    rd(3'h0, v);
    chk("falling edge flag", v, 8'h92);
    ck_irq(1'b1);
    wr(3'h0, 8'h00);
    ext_pin <= 1'b1;
    repeat (5) @(posedge clk);
    rd(3'h0, v);
    chk("unselected edge", v, 8'h00);
    // Pin change counts only on a masked pin.
    change_pins <= 8'h08;
    repeat (5) @(posedge clk);
    rd(3'h0, v);
    chk("unmasked change", v, 8'h00);
    wr(3'h6, 8'h08);
    wr(3'h0, 8'h88);
    change_pins <= 8'h00;
    repeat (5) @(posedge clk);
    rd(3'h0, v);
    chk("pin change flag", v, 8'h89);
    clear_all();
    // The core takes the request, global enable drops, and return restores it.
    wr(3'h1, 8'h40);
    wr(3'h0, 8'hC0);
    serve_en <= 1'b1;
    pulse(1);
    for (k = 0; k < 20 && service_taken !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    serve_en <= 1'b0;
    ck_irq(1'b0);
    rd(3'h0, v);
    chk("global enable after service", v, 8'h40);
    for (k = 0; k < 20 && return_from_service !== 1'b1; k++) @(negedge clk);
    ck_irq(1'b1);
    clear_all();
    tally_and_finish();
  end
endmodule // iefl_irq_ctrl_tb_top
